// ===== hw/vbr_host.sv
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module vbr_host #(
    parameter int CNT_W = 39
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic req_valid,
    input wire logic req_ready,
    output logic [31:0] req_type,
    output logic [31:0] req_reserved,
    output logic [63:0] req_sector,
    output logic dout_valid,
    input wire logic dout_ready,
    output logic [31:0] dout_data,
    input wire logic din_valid,
    output logic din_ready,
    input wire logic [31:0] din_data,
    input wire logic cpl_valid,
    input wire logic [7:0] cpl_status,
    output logic [7:0] cfg_addr,
    output logic cfg_rd,
    output logic cfg_wr,
    output logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    input wire logic cfg_ack
);
    vbr_pkg::vbr_state_t state_r;
    vbr_pkg::vbr_state_t state_nxt;
    logic [31:0] feat_r, type_r, count_r, flags_r, cfg_cmd_r;
    logic [63:0] sect_r, cfg_wval_r, cap_r;
    logic feat_ok_r, legacy_r, big_end_r, cap_valid_r;
    logic done_r, refused_r, cfg_err_r, seg_indet_r;
    logic [7:0] last_status_r;
    logic [1:0] seg_idx_r;
    logic [CNT_W-1:0] words_left_r;
    logic access, wr_en, rd_en, data_acc, data_ok;
    logic go, legal, is_rw, is_seg, cfg_start_rd, cfg_start_wr, cfg_legal;
    logic cfg_busy, cfg_done;
    logic [63:0] cfg_rval;
    logic [64:0] end_sector;
    logic word_hs;

    function automatic logic known_type(input logic [31:0] t);
        return t == vbr_pkg::TYPE_READ || t == vbr_pkg::TYPE_WRITE ||
               t == vbr_pkg::TYPE_FLUSH || t == vbr_pkg::TYPE_DISCARD ||
               t == vbr_pkg::TYPE_WZERO;
    endfunction

    assign access = psel & penable;
    assign wr_en = access & pwrite & pready;
    assign rd_en = access & ~pwrite & pready;
    assign data_acc = access && paddr == vbr_pkg::REG_DATA;
    assign data_ok = state_r == vbr_pkg::ST_DATA &&
                     (pwrite == (type_r == vbr_pkg::TYPE_WRITE));
    assign is_rw = type_r == vbr_pkg::TYPE_READ ||
                   type_r == vbr_pkg::TYPE_WRITE;
    assign is_seg = type_r == vbr_pkg::TYPE_DISCARD ||
                    type_r == vbr_pkg::TYPE_WZERO;
    assign end_sector = {1'b0, sect_r} + {33'h0, count_r};

    // Checks the staged request against the driver-side obligations
    always_comb begin
        legal = known_type(type_r);
        if (is_rw && count_r == 32'h0) begin
            legal = 1'b0;
        end
        if (is_rw && cap_valid_r && end_sector > {1'b0, cap_r}) begin
            legal = 1'b0;
        end
        if (type_r == vbr_pkg::TYPE_FLUSH &&
            (sect_r != 64'h0 || count_r != 32'h0)) begin
            legal = 1'b0;
        end
        if (is_seg && (count_r == 32'h0 || flags_r[31:1] != 31'h0)) begin
            legal = 1'b0;
        end
        if (type_r == vbr_pkg::TYPE_DISCARD && flags_r[0]) begin
            legal = 1'b0;
        end
    end

    assign go = wr_en && paddr == vbr_pkg::REG_CTRL &&
                pwdata[vbr_pkg::CTRL_GO] && state_r == vbr_pkg::ST_IDLE;

    // APB slave: only the data window can stall
    always_comb begin
        pready = 1'b1;
        pslverr = 1'b0;
        if (data_acc && data_ok) begin
            pready = pwrite ? dout_ready : din_valid;
        end else if (data_acc) begin
            pslverr = 1'b1;
        end else if (access && paddr > vbr_pkg::REG_CAP_HI) begin
            pslverr = 1'b1;
        end
    end

    assign dout_valid = (state_r == vbr_pkg::ST_SEG) ||
                        (data_acc && data_ok && pwrite);
    assign din_ready = data_acc && data_ok && !pwrite;
    assign word_hs = (dout_valid && dout_ready) || (din_valid && din_ready);

    // Segment words: start sector, sector count, flags
    always_comb begin
        dout_data = pwdata;
        if (state_r == vbr_pkg::ST_SEG) begin
            unique case (seg_idx_r)
                2'h0: dout_data = sect_r[31:0];
                2'h1: dout_data = sect_r[63:32];
                2'h2: dout_data = count_r;
                2'h3: dout_data = {31'h0, flags_r[0]};
            endcase
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            vbr_pkg::ST_IDLE: if (go && legal) state_nxt = vbr_pkg::ST_HDR;
            vbr_pkg::ST_HDR: begin
                if (req_ready) begin
                    if (is_seg) begin
                        state_nxt = vbr_pkg::ST_SEG;
                    end else if (is_rw) begin
                        state_nxt = vbr_pkg::ST_DATA;
                    end else begin
                        state_nxt = vbr_pkg::ST_WAIT;
                    end
                end
            end
            vbr_pkg::ST_SEG: begin
                if (dout_ready && seg_idx_r == vbr_pkg::SEG_LAST_WORD) begin
                    state_nxt = vbr_pkg::ST_WAIT;
                end
            end
            vbr_pkg::ST_DATA: begin
                if (word_hs && words_left_r == CNT_W'(1)) begin
                    state_nxt = vbr_pkg::ST_WAIT;
                end
            end
            vbr_pkg::ST_WAIT: if (cpl_valid) state_nxt = vbr_pkg::ST_IDLE;
            default: state_nxt = vbr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= vbr_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Header is held steady until the device takes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_valid <= 1'b0;
            req_type <= 32'h0;
            req_sector <= 64'h0;
        end else if (go && legal) begin
            req_valid <= 1'b1;
            req_type <= type_r;
            req_sector <= is_rw ? sect_r : 64'h0;
        end else if (req_valid && req_ready) begin
            req_valid <= 1'b0;
        end
    end
    assign req_reserved = 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seg_idx_r <= 2'h0;
            words_left_r <= '0;
        end else if (go && legal) begin
            seg_idx_r <= 2'h0;
            words_left_r <= CNT_W'(count_r) << vbr_pkg::WORD_SHIFT;
        end else if (state_r == vbr_pkg::ST_SEG && dout_ready) begin
            seg_idx_r <= seg_idx_r + 2'h1;
        end else if (state_r == vbr_pkg::ST_DATA && word_hs) begin
            words_left_r <= words_left_r - CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            feat_r <= 32'h0;
            type_r <= 32'h0;
            sect_r <= 64'h0;
            count_r <= 32'h0;
            flags_r <= 32'h0;
            feat_ok_r <= 1'b0;
            legacy_r <= 1'b0;
            big_end_r <= 1'b0;
            cfg_cmd_r <= 32'h0;
            cfg_wval_r <= 64'h0;
        end else if (wr_en) begin
            unique case (paddr)
                vbr_pkg::REG_CTRL: begin
                    feat_ok_r <= pwdata[vbr_pkg::CTRL_FEATURES_OK];
                    legacy_r <= pwdata[vbr_pkg::CTRL_LEGACY];
                    big_end_r <= pwdata[vbr_pkg::CTRL_BIG_ENDIAN];
                end
                vbr_pkg::REG_FEAT: feat_r <= pwdata;
                vbr_pkg::REG_TYPE: type_r <= pwdata;
                vbr_pkg::REG_SECT_LO: sect_r[31:0] <= pwdata;
                vbr_pkg::REG_SECT_HI: sect_r[63:32] <= pwdata;
                vbr_pkg::REG_COUNT: count_r <= pwdata;
                vbr_pkg::REG_FLAGS: flags_r <= pwdata;
                vbr_pkg::REG_CFG_CMD: cfg_cmd_r <= pwdata;
                vbr_pkg::REG_CFG_LO: cfg_wval_r[31:0] <= pwdata;
                vbr_pkg::REG_CFG_HI: cfg_wval_r[63:32] <= pwdata;
                default: ;
            endcase
        end
    end

    // Config access vetting before any byte reaches the device
    assign cfg_start_rd = wr_en && paddr == vbr_pkg::REG_CFG_CMD &&
                          pwdata[vbr_pkg::CCMD_RD];
    assign cfg_start_wr = wr_en && paddr == vbr_pkg::REG_CFG_CMD &&
                          pwdata[vbr_pkg::CCMD_WR] && !pwdata[vbr_pkg::CCMD_RD];
    always_comb begin
        cfg_legal = !cfg_busy;
        if (cfg_start_rd && pwdata[7:0] == vbr_pkg::CFG_WRITEBACK &&
            !legacy_r && !feat_ok_r) begin
            cfg_legal = 1'b0;
        end
        if (cfg_start_rd && pwdata[7:0] == vbr_pkg::CFG_NUM_QUEUES &&
            !feat_r[vbr_pkg::FEAT_MQ]) begin
            cfg_legal = 1'b0;
        end
        if (cfg_start_wr && (pwdata[7:0] != vbr_pkg::CFG_WRITEBACK ||
            !feat_r[vbr_pkg::FEAT_WCE] ||
            cfg_wval_r[7:0] > vbr_pkg::CACHE_WRITEBACK)) begin
            cfg_legal = 1'b0;
        end
    end

    vbr_cfg_xfer u_cfg (
        .pclk(pclk),
        .presetn(presetn),
        .start_rd(cfg_start_rd && cfg_legal),
        .start_wr(cfg_start_wr && cfg_legal),
        .offset(pwdata[7:0]),
        .nbytes(pwdata[vbr_pkg::CCMD_WIDTH_LSB +: 4]),
        .wdata(cfg_wval_r),
        .swap(legacy_r & big_end_r),
        .busy(cfg_busy),
        .done(cfg_done),
        .rdata(cfg_rval),
        .cfg_addr(cfg_addr),
        .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack)
    );

    // Capacity bounds later read and write requests once all 8 bytes of it have been read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_r <= 64'h0;
            cap_valid_r <= 1'b0;
        end else if (cfg_done && cfg_cmd_r[vbr_pkg::CCMD_RD] &&
                     cfg_cmd_r[7:0] == vbr_pkg::CFG_CAPACITY &&
                     cfg_cmd_r[vbr_pkg::CCMD_WIDTH_LSB +: 4] ==
                     vbr_pkg::CFG_CAPACITY_BYTES) begin
            cap_r <= cfg_rval;
            cap_valid_r <= 1'b1;
        end
    end

    // Sticky flags: a new event beats a same-cycle write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
            refused_r <= 1'b0;
            cfg_err_r <= 1'b0;
            seg_indet_r <= 1'b0;
            last_status_r <= vbr_pkg::STS_OK;
        end else begin
            if (wr_en && paddr == vbr_pkg::REG_STATUS) begin
                done_r <= done_r & ~pwdata[vbr_pkg::STAT_DONE];
                refused_r <= refused_r & ~pwdata[vbr_pkg::STAT_REFUSED];
                cfg_err_r <= cfg_err_r & ~pwdata[vbr_pkg::STAT_CFG_ERR];
                seg_indet_r <= seg_indet_r & ~pwdata[vbr_pkg::STAT_SEG_INDET];
            end
            if (state_r == vbr_pkg::ST_WAIT && cpl_valid) begin
                done_r <= 1'b1;
                last_status_r <= cpl_status;
                if (is_seg && cpl_status == vbr_pkg::STS_IOERR) begin
                    seg_indet_r <= 1'b1;
                end
            end
            if (go && !legal) begin
                refused_r <= 1'b1;
            end
            if ((cfg_start_rd || cfg_start_wr) && !cfg_legal) begin
                cfg_err_r <= 1'b1;
            end
        end
    end

    always_comb begin
        prdata = 32'h0;
        unique case (paddr)
            vbr_pkg::REG_CTRL: prdata = {28'h0, big_end_r, legacy_r,
                                         feat_ok_r, 1'b0};
            vbr_pkg::REG_FEAT: prdata = feat_r;
            vbr_pkg::REG_TYPE: prdata = type_r;
            vbr_pkg::REG_SECT_LO: prdata = sect_r[31:0];
            vbr_pkg::REG_SECT_HI: prdata = sect_r[63:32];
            vbr_pkg::REG_COUNT: prdata = count_r;
            vbr_pkg::REG_FLAGS: prdata = flags_r;
            vbr_pkg::REG_STATUS: prdata = {16'h0, last_status_r, 2'h0,
                cfg_busy, seg_indet_r, cfg_err_r, refused_r, done_r,
                state_r != vbr_pkg::ST_IDLE};
            vbr_pkg::REG_DATA: prdata = data_ok ? din_data : 32'h0;
            vbr_pkg::REG_CFG_CMD: prdata = cfg_cmd_r;
            vbr_pkg::REG_CFG_LO: prdata = cfg_rval[31:0];
            vbr_pkg::REG_CFG_HI: prdata = cfg_rval[63:32];
            vbr_pkg::REG_CAP_LO: prdata = cap_r[31:0];
            vbr_pkg::REG_CAP_HI: prdata = cap_r[63:32];
            default: prdata = 32'h0;
        endcase
    end

    a_hdr_type_known: assert property (@(posedge pclk) disable iff (!presetn)
        req_valid |-> known_type(req_type))
        else $error("header carries an unknown type");
    a_flush_sector_zero: assert property (@(posedge pclk)
        disable iff (!presetn)
        req_valid && req_type == vbr_pkg::TYPE_FLUSH |-> req_sector == 64'h0)
        else $error("flush sent with nonzero sector");
    a_other_sector_zero: assert property (@(posedge pclk)
        disable iff (!presetn)
        req_valid && req_type != vbr_pkg::TYPE_READ &&
        req_type != vbr_pkg::TYPE_WRITE |-> req_sector == 64'h0)
        else $error("sector not zero on non read-write request");
    a_discard_no_unmap: assert property (@(posedge pclk)
        disable iff (!presetn)
        state_r == vbr_pkg::ST_SEG && type_r == vbr_pkg::TYPE_DISCARD &&
        seg_idx_r == vbr_pkg::SEG_LAST_WORD |-> dout_data == 32'h0)
        else $error("discard segment carries a flag");
    a_cap_bound: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(req_valid) && is_rw && cap_valid_r |->
        {1'b0, req_sector} + {33'h0, count_r} <= {1'b0, cap_r})
        else $error("request reaches beyond capacity");
    a_wb_read_gated: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cfg_rd) && cfg_addr == vbr_pkg::CFG_WRITEBACK && !legacy_r
        |-> feat_ok_r)
        else $error("cache mode read before features accepted");
    a_hdr_held: assert property (@(posedge pclk) disable iff (!presetn)
        req_valid && !req_ready |=>
        req_valid && $stable(req_type) && $stable(req_sector))
        else $error("header dropped or changed before acceptance");
    a_cpl_status: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == vbr_pkg::ST_WAIT && cpl_valid |=>
        done_r && last_status_r == $past(cpl_status) &&
        state_r == vbr_pkg::ST_IDLE)
        else $error("completion status not captured");
    a_cache_write: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_wr |-> feat_r[vbr_pkg::FEAT_WCE] &&
        cfg_wdata <= vbr_pkg::CACHE_WRITEBACK)
        else $error("illegal cache mode write");
endmodule
`default_nettype wire

// ===== hw/vbr_pkg.sv
package vbr_pkg;
    // Request type codes carried in the header type word
    localparam logic [31:0] TYPE_READ = 32'h0000_0000;
    localparam logic [31:0] TYPE_WRITE = 32'h0000_0001;
    localparam logic [31:0] TYPE_FLUSH = 32'h0000_0004;
    localparam logic [31:0] TYPE_DISCARD = 32'h0000_000B;
    localparam logic [31:0] TYPE_WZERO = 32'h0000_000D;
    // Completion status byte codes
    localparam logic [7:0] STS_OK = 8'h00;
    localparam logic [7:0] STS_IOERR = 8'h01;
    localparam logic [7:0] STS_UNSUPP = 8'h02;
    // Negotiated feature bit positions
    localparam int FEAT_RO = 5;
    localparam int FEAT_FLUSH = 9;
    localparam int FEAT_WCE = 11;
    localparam int FEAT_MQ = 12;
    localparam int FEAT_DISCARD = 13;
    localparam int FEAT_WZERO = 14;
    // Device configuration space byte offsets, capacity field width and cache mode values
    localparam logic [7:0] CFG_CAPACITY = 8'h00;
    localparam logic [7:0] CFG_WRITEBACK = 8'h20;
    localparam logic [7:0] CFG_NUM_QUEUES = 8'h22;
    localparam logic [3:0] CFG_CAPACITY_BYTES = 4'h8;
    localparam logic [7:0] CACHE_WRITETHROUGH = 8'h00;
    localparam logic [7:0] CACHE_WRITEBACK = 8'h01;
    // Data framing
    localparam int SECTOR_BYTES = 512;
    localparam int WORD_SHIFT = $clog2(SECTOR_BYTES / 4);
    localparam logic [1:0] SEG_LAST_WORD = 2'h3;
    // Software register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FEAT = 8'h04;
    localparam logic [7:0] REG_TYPE = 8'h08;
    localparam logic [7:0] REG_SECT_LO = 8'h0C;
    localparam logic [7:0] REG_SECT_HI = 8'h10;
    localparam logic [7:0] REG_COUNT = 8'h14;
    localparam logic [7:0] REG_FLAGS = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1C;
    localparam logic [7:0] REG_DATA = 8'h20;
    localparam logic [7:0] REG_CFG_CMD = 8'h24;
    localparam logic [7:0] REG_CFG_LO = 8'h28;
    localparam logic [7:0] REG_CFG_HI = 8'h2C;
    localparam logic [7:0] REG_CAP_LO = 8'h30;
    localparam logic [7:0] REG_CAP_HI = 8'h34;
    // Control register fields
    localparam int CTRL_GO = 0;
    localparam int CTRL_FEATURES_OK = 1;
    localparam int CTRL_LEGACY = 2;
    localparam int CTRL_BIG_ENDIAN = 3;
    // Status register fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_REFUSED = 2;
    localparam int STAT_CFG_ERR = 3;
    localparam int STAT_SEG_INDET = 4;
    localparam int STAT_CFG_BUSY = 5;
    localparam int STAT_CODE_LSB = 8;
    // Config command fields
    localparam int CCMD_WIDTH_LSB = 8;
    localparam int CCMD_RD = 16;
    localparam int CCMD_WR = 17;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HDR = 3'b001,
        ST_SEG = 3'b010,
        ST_DATA = 3'b011,
        ST_WAIT = 3'b100
    } vbr_state_t;
endpackage

// ===== hw/vbr_cfg_xfer.sv
`timescale 1ns/1ps
`default_nettype none
// Moves a 1..8 byte configuration field one byte at a time.
module vbr_cfg_xfer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start_rd,
    input wire logic start_wr,
    input wire logic [7:0] offset,
    input wire logic [3:0] nbytes,
    input wire logic [63:0] wdata,
    input wire logic swap,
    output logic busy,
    output logic done,
    output logic [63:0] rdata,
    output logic [7:0] cfg_addr,
    output logic cfg_rd,
    output logic cfg_wr,
    output logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    input wire logic cfg_ack
);
    logic [3:0] idx_r;
    logic [3:0] len_r;
    logic [7:0] base_r;
    logic swap_r;
    logic [63:0] wbuf_r;
    logic [2:0] lane;

    // Little-endian by default; a legacy big-endian guest reverses the lanes
    assign lane = swap_r ? 3'(len_r - idx_r - 4'h1) : idx_r[2:0];
    assign busy = cfg_rd | cfg_wr;
    assign cfg_addr = 8'(base_r + {4'h0, idx_r});
    assign cfg_wdata = wbuf_r[{lane, 3'b000} +: 8];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_r <= 4'h0;
            len_r <= 4'h0;
            base_r <= 8'h00;
            swap_r <= 1'b0;
            wbuf_r <= 64'h0;
            cfg_rd <= 1'b0;
            cfg_wr <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!busy && (start_rd || start_wr) && nbytes != 4'h0) begin
                idx_r <= 4'h0;
                len_r <= nbytes;
                base_r <= offset;
                swap_r <= swap;
                wbuf_r <= wdata;
                cfg_rd <= start_rd;
                cfg_wr <= start_wr & ~start_rd;
            end else if (busy && cfg_ack) begin
                if (idx_r == len_r - 4'h1) begin
                    cfg_rd <= 1'b0;
                    cfg_wr <= 1'b0;
                    done <= 1'b1;
                end
                idx_r <= idx_r + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= 64'h0;
        end else if (!busy && start_rd) begin
            rdata <= 64'h0;
        end else if (cfg_rd && cfg_ack) begin
            rdata[{lane, 3'b000} +: 8] <= cfg_rdata;
        end
    end
endmodule
`default_nettype wire

// ===== tb/vbr_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module vbr_dev_model #(
    parameter logic [63:0] CAP = 64'h0000_0002_8000_1234
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req_valid,
    output logic req_ready,
    output logic cpl_valid,
    output logic [7:0] cpl_status,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic cfg_ack
);
    logic [3:0] cnt_r;
    logic [7:0] wb_r;
    assign req_ready = req_valid;
    assign cfg_ack = cfg_rd | cfg_wr;
    always_comb begin
        cfg_rdata = 8'h00; // Pads read zero
        if (cfg_addr < 8'h08) cfg_rdata = CAP[{cfg_addr[2:0], 3'h0} +: 8];
        if (cfg_addr == 8'h20) cfg_rdata = wb_r;
        if (!cfg_rd) cfg_rdata = 8'hA5;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wb_r <= 8'h00; // Writethrough start
        end else if (cfg_wr && cfg_addr == 8'h20) begin
            wb_r <= cfg_wdata;
        end
    end
    // Completes late so segment words land first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 4'h0;
        end else if (req_valid) begin
            cnt_r <= 4'hF;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
    // Offers no read-only or trim limits; the cache mode byte at 0x20 is writable
    // No backend is kept, so no write can alter media
    assign cpl_valid = (cnt_r == 4'h1);
    assign cpl_status = cpl_valid ? 8'h00 : 8'hFF;
endmodule
`default_nettype wire

// ===== tb/vbr_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vbr_host_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, slv, pready, pslverr, req_valid, req_ready;
    logic [7:0] paddr = 8'h00, cpl_status, cfg_addr, cfg_wdata, cfg_rdata;
    logic [31:0] pwdata = 32'h0, prdata, q, req_type, req_rsv, dout_data;
    logic [31:0] s_type, s_rsv, last_w;
    logic [63:0] req_sector, s_sect;
    logic dout_valid, din_ready, cpl_valid, cfg_rd, cfg_wr, cfg_ack;
    int err_total = 0, cmp_count = 0, nw = 0;
    always #12.5 pclk = ~pclk;
    vbr_host u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_valid(req_valid), .req_ready(req_ready), .req_type(req_type),
        .req_reserved(req_rsv), .req_sector(req_sector),
        .dout_valid(dout_valid), .dout_ready(1'b1), .dout_data(dout_data),
        .din_valid(1'b0), .din_ready(din_ready), .din_data(32'h0),
        .cpl_valid(cpl_valid), .cpl_status(cpl_status), .cfg_addr(cfg_addr),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));
    vbr_dev_model u_dev (.pclk(pclk), .presetn(presetn),
        .req_valid(req_valid), .req_ready(req_ready), .cpl_valid(cpl_valid),
        .cpl_status(cpl_status), .cfg_addr(cfg_addr), .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack));
    always @(posedge pclk) begin
        if (req_valid && req_ready) begin
            s_type = req_type;
            s_rsv = req_rsv;
            s_sect = req_sector;
        end
        if (dout_valid) begin
            nw++;
            last_w = dout_data;
        end
    end
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer is taken at the very edge that samples pready high
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stat(input int b, input logic v);
        int i;
        for (i = 0; i < 60; i++) begin
            apb(1'b0, vbr_pkg::REG_STATUS, 32'h0);
            if (q[b] === v) break;
        end
        // A poll that never sees the bit counts as a mismatch
        if (i == 60) begin
            err_total++;
            $display("[ERR] status bit %0d expected %b seen %b", b, v, q[b]);
        end
    endtask
    task automatic issue(input logic [31:0] t, input logic [31:0] s,
        input logic [31:0] c, input logic [31:0] f);
        apb(1'b1, vbr_pkg::REG_STATUS, 32'h0000_001E);
        apb(1'b1, vbr_pkg::REG_TYPE, t);
        apb(1'b1, vbr_pkg::REG_SECT_LO, s);
        apb(1'b1, vbr_pkg::REG_COUNT, c);
        apb(1'b1, vbr_pkg::REG_FLAGS, f);
        apb(1'b1, vbr_pkg::REG_CTRL, 32'h0000_0003);
        stat(vbr_pkg::STAT_BUSY, 1'b0);
    endtask
    task automatic t_cfg();
        apb(1'b1, vbr_pkg::REG_CFG_CMD, 32'h0001_0800);
        stat(vbr_pkg::STAT_CFG_BUSY, 1'b0);
        apb(1'b0, vbr_pkg::REG_CAP_LO, 32'h0);
        chk("cap_lo", 32'h8000_1234, q);
        apb(1'b0, vbr_pkg::REG_CAP_HI, 32'h0);
        chk("cap_hi", 32'h0000_0002, q);
        apb(1'b1, vbr_pkg::REG_CFG_CMD, 32'h0001_0120);
        stat(vbr_pkg::STAT_CFG_ERR, 1'b1);
        chk("wb_early", 32'h1, {31'h0, q[3]});
        apb(1'b1, vbr_pkg::REG_STATUS, 32'h0000_0008);
        apb(1'b1, vbr_pkg::REG_CFG_CMD, 32'h0001_0222);
        stat(vbr_pkg::STAT_CFG_ERR, 1'b1);
        chk("queues_no_mq", 32'h1, {31'h0, q[3]});
    endtask
    task automatic t_flush();
        issue(vbr_pkg::TYPE_FLUSH, 32'h0, 32'h0, 32'h0);
        chk("flush_type", 32'h4, s_type);
        chk("flush_sect", 32'h0, s_sect[31:0]);
        chk("rsv", 32'h0, s_rsv);
        chk("sts", {24'h0, vbr_pkg::STS_OK}, {24'h0, q[15:8]});
    endtask
    task automatic t_zero();
        nw = 0;
        issue(vbr_pkg::TYPE_WZERO, 32'h5, 32'h2, 32'h1);
        chk("wz_type", 32'hD, s_type);
        chk("wz_sect", 32'h0, s_sect[31:0]);
        chk("seg_words", 32'h4, nw);
        chk("seg_flags", 32'h1, last_w);
    endtask
    task automatic t_bad();
        issue(vbr_pkg::TYPE_DISCARD, 32'h0, 32'h2, 32'h1);
        chk("trim_unmap", 32'h1, {31'h0, q[2]});
        chk("no_req", 32'hD, s_type);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, {31'h0, slv});
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_cfg();
        t_flush();
        t_zero();
        t_bad();
        close_out();
    end
    initial begin
        #300us;
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
